// File: lmt_defs.svh
// Constants for the legacy mode and trap control block
`ifndef LMT_DEFS_SVH
`define LMT_DEFS_SVH

`define LMT_ADDR_W         32
`define LMT_PAGE_SHIFT     12
`define LMT_VPN_W          20
`define LMT_TLB_DEPTH      32
`define LMT_LEGACY_AW      20
`define LMT_PTE_IDX_SHIFT  2
`define LMT_IO_PRIVILEGE_LEVEL_FULL      2'h3
`define LMT_PTE_P_BIT      0
`define LMT_PTE_W_BIT      1
`define LMT_PTE_D_BIT      6
`define LMT_FLAG_RST       1'h0
`define LMT_IMAGE_RST      1'h0

`endif

// File: lmt_pkg.sv
// Types shared by the legacy mode and trap control block
`default_nettype none
`include "lmt_defs.svh"

package lmt_pkg;

	typedef enum logic [1:0] {LMT_REAL, LMT_PROT, LMT_LEGACY} lmt_mode_t;

	typedef enum logic [2:0] {LMT_I_OTHER, LMT_I_CLI, LMT_I_STI, LMT_I_INT, LMT_I_IO} lmt_instr_t;

	typedef enum logic [1:0] {LMT_C_NONE, LMT_C_INTF, LMT_C_SWINT, LMT_C_IO} lmt_cause_t;

	typedef struct packed {
		logic       valid;
		lmt_cause_t cause;
	} lmt_trap_t;

	typedef struct packed {
		logic [`LMT_VPN_W-1:0] vpn;
		logic [`LMT_VPN_W-1:0] frame;
		logic                  present;
		logic                  writable;
		logic                  dirty;
	} lmt_tlb_entry_t;

endpackage : lmt_pkg

`default_nettype wire

// File: lmt_tlb_mem.sv
// Translation cache storage with registered read data
`timescale 1ns/1ps
`default_nettype none

module lmt_tlb_mem #(
	parameter int DEPTH = 32,
	parameter int WIDTH = 43,
	parameter int AW    = $clog2(DEPTH)
) (
	input  wire logic             mclk,
	input  wire logic [AW-1:0]    rd_addr,
	output logic      [WIDTH-1:0] rd_data,
	input  wire logic             we,
	input  wire logic [AW-1:0]    wr_addr,
	input  wire logic [WIDTH-1:0] wr_data
);

	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
		$error("lmt_tlb_mem: DEPTH must be a power of two of at least 2");
	end

	logic [WIDTH-1:0] mem [DEPTH];

	// No reset: slot validity is kept by the owner in flip-flops
	always_ff @(posedge mclk) begin
		if (we) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end

endmodule : lmt_tlb_mem

`default_nettype wire

// File: lmt_core.sv
// Legacy mode control, sensitive instruction traps and paging stage
//
// Summary of operation
// [RQ1] After reset the processor runs in real mode, not protected mode.
// [RQ2] Task switch from a record with the legacy flag set enters legacy emulation.
// [RQ3] Task switch from a record with the flag clear leaves legacy emulation.
// [RQ4] Any exception or interrupt taken leaves legacy emulation for the handler.
// [RQ5] Returning from such a handler restores legacy emulation for the task.
// [RQ6] The flags image saved at exception entry carries the legacy flag.
// [RQ7] Legacy task addresses fall in the lowest megabyte of linear space.
// [RQ8] Interrupt-flag instructions in legacy emulation trap instead of executing.
// [RQ9] Software interrupt instruction in legacy emulation traps to the monitor.
// [RQ10] In legacy emulation, I/O instructions trap when I/O privilege is below 3.
// [RQ11] Read-only pages trap writes; not-present pages trap reads and writes.
// [RQ12] Paging off passes addresses unchanged; paging on translates and checks.
// [RQ13] A 32-entry translation cache is consulted before the page tables.
// [RQ14] On a miss, write back the old entry, then refill the slot by bus.
// [RQ15] Entry saves the flags image before clearing the legacy flag.
`timescale 1ns/1ps
`default_nettype none
`include "lmt_defs.svh"

module lmt_core #(
	parameter int TLB_DEPTH = `LMT_TLB_DEPTH
) (
	input  wire logic                     mclk,
	input  wire logic                     resetn,
	input  wire logic                     pe_enable,
	input  wire logic                     paging_enable,
	input  wire logic [1:0]               io_privilege_level,
	input  wire logic                     task_switch,
	input  wire logic                     task_legacy_flag,
	input  wire logic                     exc_enter,
	input  wire logic                     exc_return,
	input  wire logic                     ret_image_legacy,
	input  wire logic                     instr_valid,
	input  wire lmt_pkg::lmt_instr_t      instr_class,
	input  wire logic                     req_valid,
	input  wire logic                     req_write,
	input  wire logic [`LMT_ADDR_W-1:0]   seg_addr,
	input  wire logic [`LMT_ADDR_W-1:0]   table_base,
	input  wire logic                     bus_ready,
	input  wire logic [`LMT_ADDR_W-1:0]   bus_rdata,
	output lmt_pkg::lmt_mode_t            mode,
	output logic                          legacy_emulation_flag,
	output logic                          image_legacy,
	output logic                          image_valid,
	output lmt_pkg::lmt_trap_t            trap,
	output logic                          req_ready,
	output logic                          xlat_valid,
	output logic [`LMT_ADDR_W-1:0]        xlat_addr,
	output logic                          xlat_fault,
	output logic                          bus_req,
	output logic                          bus_write,
	output logic [`LMT_ADDR_W-1:0]        bus_addr,
	output logic [`LMT_ADDR_W-1:0]        bus_wdata
);
	import lmt_pkg::*;

	localparam int IDX_W = $clog2(TLB_DEPTH);
	localparam int ENT_W = $bits(lmt_tlb_entry_t);

	if (TLB_DEPTH < 2 || (1 << IDX_W) != TLB_DEPTH || IDX_W > `LMT_VPN_W) begin : g_bad_depth
		$error("lmt_core: TLB_DEPTH must be a power of two between 2 and 2**20");
	end

	typedef enum logic [1:0] {S_IDLE, S_LOOK, S_WBACK, S_FILL} lmt_walk_t;

	// ************************************************************
	// Helpers
	// ************************************************************
	function automatic logic page_fault_f(input logic present, input logic writable,
		input logic wr);
		page_fault_f = !present || (wr && !writable); // [RQ11]
	endfunction : page_fault_f

	function automatic logic [`LMT_ADDR_W-1:0] pte_addr_f(input logic [`LMT_ADDR_W-1:0] base,
		input logic [`LMT_VPN_W-1:0] vpn);
		pte_addr_f = base + {{(`LMT_ADDR_W-`LMT_VPN_W-`LMT_PTE_IDX_SHIFT){1'b0}}, vpn,
			{`LMT_PTE_IDX_SHIFT{1'b0}}};
	endfunction : pte_addr_f

	// ************************************************************
	// Mode and legacy flag
	// ************************************************************
	lmt_mode_t next_mode;
	logic      next_flag;
	logic      next_image_legacy;
	logic      next_image_valid;
	lmt_trap_t next_trap;

	always_comb begin
		next_flag         = legacy_emulation_flag;
		next_image_legacy = image_legacy;
		next_image_valid  = 1'b0;
		if (exc_enter) begin
			// Image takes the old flag on the same edge that clears it
			next_image_legacy = legacy_emulation_flag; // [RQ6] [RQ15]
			next_image_valid  = 1'b1;
			next_flag         = 1'b0; // [RQ4]
		end else if (exc_return) begin
			next_flag = ret_image_legacy; // [RQ5]
		end else if (task_switch) begin
			next_flag = task_legacy_flag; // [RQ2] [RQ3]
		end
		// Legacy emulation exists only under protection
		if (!pe_enable) begin
			next_flag = 1'b0;
		end
		if (!pe_enable) begin
			next_mode = LMT_REAL; // [RQ1]
		end else if (next_flag) begin
			next_mode = LMT_LEGACY;
		end else begin
			next_mode = LMT_PROT;
		end
		next_trap = '{valid: 1'b0, cause: LMT_C_NONE};
		if (instr_valid && legacy_emulation_flag) begin
			case (instr_class)
				LMT_I_CLI, LMT_I_STI: next_trap = '{valid: 1'b1, cause: LMT_C_INTF}; // [RQ8]
				LMT_I_INT: next_trap = '{valid: 1'b1, cause: LMT_C_SWINT}; // [RQ9]
				LMT_I_IO: begin
					if (io_privilege_level < `LMT_IO_PRIVILEGE_LEVEL_FULL) begin
						next_trap = '{valid: 1'b1, cause: LMT_C_IO}; // [RQ10]
					end
				end
				default: next_trap = '{valid: 1'b0, cause: LMT_C_NONE};
			endcase
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			mode                  <= LMT_REAL; // [RQ1]
			legacy_emulation_flag <= `LMT_FLAG_RST;
			image_legacy          <= `LMT_IMAGE_RST;
			image_valid           <= 1'b0;
			trap                  <= '{valid: 1'b0, cause: LMT_C_NONE};
		end else begin
			mode                  <= next_mode;
			legacy_emulation_flag <= next_flag;
			image_legacy          <= next_image_legacy;
			image_valid           <= next_image_valid;
			trap                  <= next_trap;
		end
	end

	// ************************************************************
	// Paging stage
	// ************************************************************
	lmt_walk_t             state, next_state;
	logic [`LMT_ADDR_W-1:0] lin_in, lin_q, next_lin_q;
	logic                  wr_q, next_wr_q;
	logic [TLB_DEPTH-1:0]  slot_valid, next_slot_valid;
	logic                  next_ready, next_xlat_valid, next_xlat_fault;
	logic [`LMT_ADDR_W-1:0] next_xlat_addr, next_bus_addr, next_bus_wdata;
	logic                  next_bus_req, next_bus_write;
	logic [IDX_W-1:0]      rd_idx, q_idx;
	logic [ENT_W-1:0]      mem_rvec;
	lmt_tlb_entry_t        ent, fill_ent;
	logic                  mem_we;
	logic                  hit;

	// Legacy tasks see only the low megabyte before relocation
	assign lin_in = legacy_emulation_flag ?
		{{(`LMT_ADDR_W-`LMT_LEGACY_AW){1'b0}}, seg_addr[`LMT_LEGACY_AW-1:0]} : seg_addr; // [RQ7]
	assign rd_idx = lin_in[`LMT_PAGE_SHIFT +: IDX_W];
	assign q_idx  = lin_q[`LMT_PAGE_SHIFT +: IDX_W];
	assign ent    = lmt_tlb_entry_t'(mem_rvec);
	assign hit    = slot_valid[q_idx] && (ent.vpn == lin_q[`LMT_ADDR_W-1:`LMT_PAGE_SHIFT]);

	// Direct mapped: the slot is chosen by the low page number bits
	lmt_tlb_mem #(
		.DEPTH   (TLB_DEPTH),
		.WIDTH   (ENT_W),
		.AW      (IDX_W)
	) u_tlb ( // [RQ13]
		.mclk    (mclk),
		.rd_addr (rd_idx),
		.rd_data (mem_rvec),
		.we      (mem_we),
		.wr_addr (q_idx),
		.wr_data (fill_ent)
	);

	always_comb begin
		next_state      = state;
		next_lin_q      = lin_q;
		next_wr_q       = wr_q;
		next_slot_valid = slot_valid;
		next_xlat_valid = 1'b0;
		next_xlat_fault = 1'b0;
		next_xlat_addr  = xlat_addr;
		next_bus_req    = bus_req;
		next_bus_write  = bus_write;
		next_bus_addr   = bus_addr;
		next_bus_wdata  = bus_wdata;
		mem_we          = 1'b0;
		fill_ent        = ent;
		case (state)
			S_IDLE: begin
				if (req_valid && req_ready) begin
					if (!paging_enable) begin
						next_xlat_valid = 1'b1; // [RQ12]
						next_xlat_addr  = lin_in;
					end else begin
						next_lin_q = lin_in;
						next_wr_q  = req_write;
						next_state = S_LOOK;
					end
				end
			end
			S_LOOK: begin
				if (hit) begin
					next_xlat_valid = 1'b1;
					next_xlat_fault = page_fault_f(ent.present, ent.writable, wr_q); // [RQ11]
					next_xlat_addr  = {ent.frame, lin_q[`LMT_PAGE_SHIFT-1:0]}; // [RQ12]
					next_state      = S_IDLE;
					// Dirty is kept in the cache and reaches the table on eviction
					if (wr_q && !ent.dirty && !next_xlat_fault) begin
						fill_ent.dirty = 1'b1;
						mem_we         = 1'b1;
					end
				end else if (slot_valid[q_idx]) begin
					next_bus_req   = 1'b1; // [RQ14]
					next_bus_write = 1'b1;
					next_bus_addr  = pte_addr_f(table_base, ent.vpn);
					next_bus_wdata = '0;
					next_bus_wdata[`LMT_ADDR_W-1:`LMT_PAGE_SHIFT] = ent.frame;
					next_bus_wdata[`LMT_PTE_P_BIT] = ent.present;
					next_bus_wdata[`LMT_PTE_W_BIT] = ent.writable;
					next_bus_wdata[`LMT_PTE_D_BIT] = ent.dirty;
					next_state     = S_WBACK;
				end else begin
					next_bus_req   = 1'b1; // [RQ14]
					next_bus_write = 1'b0;
					next_bus_addr  = pte_addr_f(table_base, lin_q[`LMT_ADDR_W-1:`LMT_PAGE_SHIFT]);
					next_state     = S_FILL;
				end
			end
			S_WBACK: begin
				if (bus_ready) begin
					next_slot_valid[q_idx] = 1'b0;
					next_bus_write = 1'b0; // [RQ14]
					next_bus_addr  = pte_addr_f(table_base, lin_q[`LMT_ADDR_W-1:`LMT_PAGE_SHIFT]);
					next_state     = S_FILL;
				end
			end
			S_FILL: begin
				if (bus_ready) begin
					fill_ent.vpn      = lin_q[`LMT_ADDR_W-1:`LMT_PAGE_SHIFT];
					fill_ent.frame    = bus_rdata[`LMT_ADDR_W-1:`LMT_PAGE_SHIFT];
					fill_ent.present  = bus_rdata[`LMT_PTE_P_BIT];
					fill_ent.writable = bus_rdata[`LMT_PTE_W_BIT];
					fill_ent.dirty    = bus_rdata[`LMT_PTE_D_BIT]
						| (wr_q & bus_rdata[`LMT_PTE_W_BIT]);
					next_xlat_valid   = 1'b1;
					next_xlat_fault   = page_fault_f(fill_ent.present, fill_ent.writable, wr_q);
					next_xlat_addr    = {fill_ent.frame, lin_q[`LMT_PAGE_SHIFT-1:0]};
					// Not-present pages are never cached so a later fix is seen at once
					mem_we            = fill_ent.present; // [RQ14]
					next_slot_valid[q_idx] = fill_ent.present;
					next_bus_req      = 1'b0;
					next_state        = S_IDLE;
				end
			end
			default: next_state = S_IDLE;
		endcase
		next_ready = (next_state == S_IDLE);
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state      <= S_IDLE;
			lin_q      <= '0;
			wr_q       <= 1'b0;
			slot_valid <= '0;
			req_ready  <= 1'b1;
			xlat_valid <= 1'b0;
			xlat_fault <= 1'b0;
			xlat_addr  <= '0;
			bus_req    <= 1'b0;
			bus_write  <= 1'b0;
			bus_addr   <= '0;
			bus_wdata  <= '0;
		end else begin
			state      <= next_state;
			lin_q      <= next_lin_q;
			wr_q       <= next_wr_q;
			slot_valid <= next_slot_valid;
			req_ready  <= next_ready;
			xlat_valid <= next_xlat_valid;
			xlat_fault <= next_xlat_fault;
			xlat_addr  <= next_xlat_addr;
			bus_req    <= next_bus_req;
			bus_write  <= next_bus_write;
			bus_addr   <= next_bus_addr;
			bus_wdata  <= next_bus_wdata;
		end
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	property p_real;
		@(posedge mclk) disable iff (!resetn)
		!pe_enable |=> (mode == LMT_REAL) && !legacy_emulation_flag;
	endproperty
	a_real: assert property (p_real) else $error("mode not real without protection"); // [RQ1]

	property p_enter;
		@(posedge mclk) disable iff (!resetn)
		task_switch && task_legacy_flag && !exc_enter && !exc_return && pe_enable
		|=> legacy_emulation_flag && (mode == LMT_LEGACY);
	endproperty
	a_enter: assert property (p_enter) else $error("legacy mode not entered"); // [RQ2]

	property p_exit;
		@(posedge mclk) disable iff (!resetn)
		task_switch && !task_legacy_flag && !exc_enter && !exc_return |=> !legacy_emulation_flag;
	endproperty
	a_exit: assert property (p_exit) else $error("legacy mode not left on task switch"); // [RQ3]

	property p_leave;
		@(posedge mclk) disable iff (!resetn)
		exc_enter |=> !legacy_emulation_flag && (mode != LMT_LEGACY);
	endproperty
	a_leave: assert property (p_leave) else $error("handler entered in legacy mode"); // [RQ4]

	sequence s_entry_then_return;
		exc_enter && legacy_emulation_flag ##1 exc_return && ret_image_legacy && image_legacy
			&& !exc_enter && pe_enable;
	endsequence
	property p_resume;
		@(posedge mclk) disable iff (!resetn) s_entry_then_return |=> legacy_emulation_flag;
	endproperty
	a_resume: assert property (p_resume) else $error("legacy mode not resumed"); // [RQ5]

	property p_image;
		@(posedge mclk) disable iff (!resetn)
		exc_enter |=> image_valid && (image_legacy == $past(legacy_emulation_flag));
	endproperty
	a_image: assert property (p_image) else $error("saved image lost legacy flag"); // [RQ6] [RQ15]

	property p_low_mb;
		@(posedge mclk) disable iff (!resetn)
		state == S_IDLE && req_valid && req_ready && !paging_enable && legacy_emulation_flag
		|=> xlat_valid && (xlat_addr[`LMT_ADDR_W-1:`LMT_LEGACY_AW] == '0);
	endproperty
	a_low_mb: assert property (p_low_mb) else $error("legacy address above first megabyte"); // [RQ7]

	property p_trap_if;
		@(posedge mclk) disable iff (!resetn)
		instr_valid && legacy_emulation_flag && (instr_class inside {LMT_I_CLI, LMT_I_STI})
		|=> trap.valid && (trap.cause == LMT_C_INTF);
	endproperty
	a_trap_if: assert property (p_trap_if) else $error("flag instruction not trapped"); // [RQ8]

	property p_trap_int;
		@(posedge mclk) disable iff (!resetn)
		instr_valid && legacy_emulation_flag && instr_class == LMT_I_INT
		|=> trap.valid && (trap.cause == LMT_C_SWINT);
	endproperty
	a_trap_int: assert property (p_trap_int) else $error("software interrupt not trapped"); // [RQ9]

	property p_trap_io;
		@(posedge mclk) disable iff (!resetn)
		instr_valid && legacy_emulation_flag && instr_class == LMT_I_IO
		|=> trap.valid == ($past(io_privilege_level) != 2'h3);
	endproperty
	a_trap_io: assert property (p_trap_io) else $error("I/O trap wrong for privilege level"); // [RQ10]

	property p_ro_write;
		@(posedge mclk) disable iff (!resetn)
		state == S_LOOK && hit && wr_q && !ent.writable |=> xlat_valid && xlat_fault;
	endproperty
	a_ro_write: assert property (p_ro_write) else $error("write to read-only page not trapped"); // [RQ11]

	property p_pass;
		@(posedge mclk) disable iff (!resetn)
		state == S_IDLE && req_valid && req_ready && !paging_enable
		|=> xlat_valid && !xlat_fault && (xlat_addr == $past(lin_in));
	endproperty
	a_pass: assert property (p_pass) else $error("unpaged address altered"); // [RQ12]

	sequence s_wback_then_fill;
		(bus_req && bus_write) ##[1:8] (bus_req && !bus_write);
	endsequence
	property p_refill;
		@(posedge mclk) disable iff (!resetn)
		state == S_LOOK && !hit && slot_valid[q_idx] |=> s_wback_then_fill;
	endproperty
	a_refill: assert property (p_refill) else $error("miss did not write back then refill"); // [RQ14]

	// A bus cycle may not change under the table memory before it answers
	property p_bus_hold;
		@(posedge mclk) disable iff (!resetn)
		bus_req && !bus_ready |=> bus_req && $stable(bus_write) && $stable(bus_addr);
	endproperty
	a_bus_hold: assert property (p_bus_hold) else $error("bus cycle changed before ready"); // [RQ14]

endmodule : lmt_core

`default_nettype wire

// File: lmt_core_test.sv
// Self-checking testbench for the legacy mode and trap control core
`timescale 1ns/1ps
`default_nettype none
`include "lmt_defs.svh"

module lmt_core_test;
	import lmt_pkg::*;

	// ********************************************************************
	// Stimulus and observed signals
	// ********************************************************************
	logic               mclk, resetn, pe_enable, paging_enable;
	logic [1:0]         io_privilege_level;
	logic               task_switch, task_legacy_flag, exc_enter, exc_return;
	logic               ret_image_legacy, instr_valid, req_valid, req_write, bus_ready;
	lmt_instr_t         instr_class;
	logic [31:0]        seg_addr, table_base, bus_rdata, xlat_addr, bus_addr, bus_wdata;
	lmt_mode_t          mode;
	lmt_trap_t          trap;
	logic               legacy_emulation_flag, image_legacy, image_valid, req_ready;
	logic               xlat_valid, xlat_fault, bus_req, bus_write;
	int                 num_errors, n_checks, cycles, nb;
	logic               bw [0:3];
	logic [31:0]        ba [0:3];
	logic [31:0]        bd [0:3];
	logic [31:0]        pa;
	logic               flt;

	lmt_core i_lmt_core (.mclk(mclk), .resetn(resetn), .pe_enable(pe_enable),
		.paging_enable(paging_enable), .io_privilege_level(io_privilege_level),
		.task_switch(task_switch), .task_legacy_flag(task_legacy_flag),
		.exc_enter(exc_enter), .exc_return(exc_return), .ret_image_legacy(ret_image_legacy),
		.instr_valid(instr_valid), .instr_class(instr_class), .req_valid(req_valid),
		.req_write(req_write), .seg_addr(seg_addr), .table_base(table_base),
		.bus_ready(bus_ready), .bus_rdata(bus_rdata), .mode(mode),
		.legacy_emulation_flag(legacy_emulation_flag), .image_legacy(image_legacy),
		.image_valid(image_valid), .trap(trap), .req_ready(req_ready),
		.xlat_valid(xlat_valid), .xlat_addr(xlat_addr), .xlat_fault(xlat_fault),
		.bus_req(bus_req), .bus_write(bus_write), .bus_addr(bus_addr), .bus_wdata(bus_wdata));

	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	// Whole run needs well under a thousand cycles
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			num_errors = num_errors + 1;
			tally_and_finish();
		end
	end

	// ********************************************************************
	// Shared tasks
	// ********************************************************************
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks = n_checks + 1;
		if (got !== exp) begin
			num_errors = num_errors + 1;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : tally_and_finish

	// One-cycle mode event, then look at the settled result
	task automatic ev(input logic ts, input logic tf, input logic ee, input logic er,
			input logic rl);
		@(posedge mclk);
		task_switch <= ts;
		task_legacy_flag <= tf;
		exc_enter <= ee;
		exc_return <= er;
		ret_image_legacy <= rl;
		@(posedge mclk);
		task_switch <= 1'b0;
		exc_enter <= 1'b0;
		exc_return <= 1'b0;
		@(negedge mclk);
	endtask : ev

	task automatic ins(input lmt_instr_t c, input logic [1:0] pl, input logic [2:0] exp);
		@(posedge mclk);
		instr_valid <= 1'b1;
		instr_class <= c;
		io_privilege_level <= pl;
		@(posedge mclk);
		instr_valid <= 1'b0;
		@(negedge mclk);
		check("trap", {29'h0, exp}, {29'h0, trap});
	endtask : ins

	// Issues one request and serves its bus cycles; slow adds wait states
	task automatic xlat(input logic [31:0] a, input logic w, input logic [31:0] pte,
			input int slow);
		bit done;
		done = 0;
		nb = 0;
		@(posedge mclk);
		req_valid <= 1'b1;
		req_write <= w;
		seg_addr <= a;
		@(posedge mclk);
		req_valid <= 1'b0;
		seg_addr <= ~a;
		for (int i = 0; i < 60 && !done; i++) begin
			@(negedge mclk);
			if (xlat_valid === 1'b1) begin
				done = 1;
				pa = xlat_addr;
				flt = xlat_fault;
			end else if (bus_req === 1'b1 && bus_ready === 1'b0 && nb < 4) begin
				bw[nb] = bus_write;
				ba[nb] = bus_addr;
				bd[nb] = bus_wdata;
				nb = nb + 1;
				repeat (slow + 1) @(posedge mclk);
				bus_ready <= 1'b1;
				bus_rdata <= pte;
				@(posedge mclk);
				bus_ready <= 1'b0;
				bus_rdata <= ~pte;
			end
		end
		check("xlat_done", 32'h1, 32'(done));
	endtask : xlat

	// ********************************************************************
	// Scenarios
	// ********************************************************************
	task automatic t_reset();
		check("mode", 32'(LMT_REAL), 32'(mode));
		check("flag", 32'h0, 32'(legacy_emulation_flag));
		check("req_ready", 32'h1, 32'(req_ready));
		ev(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
		check("flag_real", 32'h0, 32'(legacy_emulation_flag));
		$display("test reset done");
	endtask : t_reset

	task automatic t_modes();
		@(posedge mclk);
		pe_enable <= 1'b1;
		ev(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
		check("mode", 32'(LMT_LEGACY), 32'(mode));
		check("flag", 32'h1, 32'(legacy_emulation_flag));
		// Task switch in the same cycle as entry is dropped
		ev(1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
		check("image_valid", 32'h1, 32'(image_valid));
		check("image_legacy", 32'h1, 32'(image_legacy));
		check("flag", 32'h0, 32'(legacy_emulation_flag));
		check("mode", 32'(LMT_PROT), 32'(mode));
		@(negedge mclk);
		check("image_pulse", 32'h0, 32'(image_valid));
		ev(1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
		check("mode", 32'(LMT_LEGACY), 32'(mode));
		check("image_hold", 32'h1, 32'(image_legacy));
		ev(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
		check("mode", 32'(LMT_PROT), 32'(mode));
		check("flag", 32'h0, 32'(legacy_emulation_flag));
		ev(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
		check("image_legacy", 32'h0, 32'(image_legacy));
		// Return straight after entry resumes emulation
		ev(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
		@(posedge mclk);
		exc_enter <= 1'b1;
		@(posedge mclk);
		exc_enter <= 1'b0;
		exc_return <= 1'b1;
		ret_image_legacy <= 1'b1;
		@(posedge mclk);
		exc_return <= 1'b0;
		@(negedge mclk);
		check("resume_flag", 32'h1, 32'(legacy_emulation_flag));
		check("resume_mode", 32'(LMT_LEGACY), 32'(mode));
		$display("test modes done");
	endtask : t_modes

	task automatic t_traps();
		ev(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
		ins(LMT_I_CLI, 2'h3, {1'b1, LMT_C_INTF});
		ins(LMT_I_STI, 2'h3, {1'b1, LMT_C_INTF});
		ins(LMT_I_INT, 2'h3, {1'b1, LMT_C_SWINT});
		ins(LMT_I_IO, 2'h2, {1'b1, LMT_C_IO});
		ins(LMT_I_IO, 2'h0, {1'b1, LMT_C_IO});
		ins(LMT_I_IO, 2'h3, 3'h0);
		ins(LMT_I_OTHER, 2'h0, 3'h0);
		ev(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
		ins(LMT_I_INT, 2'h0, 3'h0);
		ins(LMT_I_CLI, 2'h0, 3'h0);
		$display("test traps done");
	endtask : t_traps

	task automatic t_flat();
		ev(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
		xlat(32'hFFF1_2345, 1'b0, 32'h0, 0);
		check("masked", 32'h0001_2345, pa);
		check("nbus", 32'h0, 32'(nb));
		ev(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
		xlat(32'hFFF1_2345, 1'b1, 32'h0, 0);
		check("pass", 32'hFFF1_2345, pa);
		check("fault", 32'h0, 32'(flt));
		$display("test flat done");
	endtask : t_flat

	task automatic t_paged();
		@(posedge mclk);
		paging_enable <= 1'b1;
		xlat(32'h0000_5123, 1'b0, 32'hABCD_E003, 0);
		check("nbus", 32'h1, 32'(nb));
		check("rd_kind", 32'h0, 32'(bw[0]));
		check("rd_addr", 32'h0010_0014, ba[0]);
		check("paddr", 32'hABCD_E123, pa);
		xlat(32'h0000_5FFC, 1'b1, 32'h0, 0);
		check("hit_nbus", 32'h0, 32'(nb));
		check("hit_paddr", 32'hABCD_EFFC, pa);
		check("hit_fault", 32'h0, 32'(flt));
		// Same slot, occupied and dirty: write back must precede refill
		xlat(32'h0002_5456, 1'b0, 32'h1234_5001, 3);
		check("nbus", 32'h2, 32'(nb));
		check("wb_kind", 32'h1, 32'(bw[0]));
		check("wb_addr", 32'h0010_0014, ba[0]);
		check("wb_data", 32'hABCD_E043, bd[0]);
		check("rf_kind", 32'h0, 32'(bw[1]));
		check("rf_addr", 32'h0010_0094, ba[1]);
		check("paddr", 32'h1234_5456, pa);
		xlat(32'h0002_5000, 1'b1, 32'h0, 0);
		check("ro_fault", 32'h1, 32'(flt));
		check("ro_nbus", 32'h0, 32'(nb));
		xlat(32'h0000_7010, 1'b0, 32'h5555_5002, 1);
		check("np_fault", 32'h1, 32'(flt));
		check("np_addr", 32'h0010_001C, ba[0]);
		xlat(32'h0000_7010, 1'b1, 32'h5555_5002, 0);
		check("np_wfault", 32'h1, 32'(flt));
		check("np_nbus", 32'h1, 32'(nb));
		$display("test paged done");
	endtask : t_paged

	// ********************************************************************
	// Main sequence
	// ********************************************************************
	initial begin
		num_errors = 0;
		n_checks = 0;
		cycles = 0;
		resetn = 1'b0;
		{pe_enable, paging_enable, task_switch, task_legacy_flag} = 4'h0;
		{exc_enter, exc_return, ret_image_legacy, instr_valid} = 4'h0;
		{req_valid, req_write, bus_ready} = 3'h0;
		io_privilege_level = 2'h3;
		instr_class = LMT_I_OTHER;
		seg_addr = 32'h0;
		table_base = 32'h0010_0000;
		bus_rdata = 32'hFFFF_FFFF;
		repeat (3) @(posedge mclk);
		resetn <= 1'b1;
		@(negedge mclk);
		t_reset();
		t_modes();
		t_traps();
		t_flat();
		t_paged();
		tally_and_finish();
	end

endmodule : lmt_core_test

`default_nettype wire
